// *** hdl/ecl_loader.sv ***
// Purpose: Boot loader, CRC check, address select and write flows of the configuration store.
// Assumes: I2C bytes come decoded from a bit engine on clk_sys_i; the page pin level is asynchronous.
// Notes:   Bank writes leave on reg_wr_*; commit words are fetched combinationally via commit_word_i.
// Operation
// - Slave address is six fixed upper bits plus the stored low bit.
// - Fall-back boot answers on its own fixed address.
// - Page one with stored low bit zero answers at 68h.
// - Factory page zero keeps serial access off and runs pin mode.
// - A transfer is address byte, 16-bit offset, then 16-bit value.
// - Page pin sampled once after reset: low page 0, high page 1, mid default.
// - Page boot (pin low or high) reads the store, computes CRC, compares with stored CRC word; fall-back boot reads nothing.
// - Writing the CRC-update bit in idle, with no commit started, rescans and refreshes live CRC and match.
// - A CRC mismatch only sets status and blocks nothing.
// - Match bit and live CRC value are visible.
// - CRC uses polynomial x16+x12+x5+1.
// - Store writes only while the unlock key equals 5h.
// - Commit copies the base words and the selected page's words into the store.
// - Commit targets the selected page and starts on the trigger bit.
// - Recalibration bit starts a VCO calibration.
// - Direct access sees 64 words of 16 bits.
// - Each unlocked data write in idle programs a word and bumps the word address.
// - Store holds base page, page zero and page one.
// - Base words 0-15, page zero 16-39, page one 40-63.
// - Each loaded word goes to the bank by fixed mapping.
`timescale 1ns/1ps
`default_nettype none
`include "ecl_defs.svh"
module ecl_loader #(
  parameter int unsigned WR_CYC = `ECL_NVM_WR_TIME_US * `ECL_CLK_MHZ,
  parameter int unsigned CNT_W  = 21
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic [1:0]  page_select_level_i,
  input  wire logic        i2c_start_i,
  input  wire logic        i2c_stop_i,
  input  wire logic        i2c_byte_valid_i,
  input  wire logic [7:0]  i2c_byte_i,
  input  wire logic [15:0] commit_word_i,
  output logic             i2c_ack_o,
  output logic             reg_wr_valid_o,
  output logic [15:0]      reg_wr_offset_o,
  output logic [15:0]      reg_wr_data_o,
  output logic             load_valid_o,
  output logic [5:0]       load_word_idx_o,
  output logic [15:0]      load_word_o,
  output logic [5:0]       commit_word_idx_o,
  output logic             vco_recalibrate_o,
  output logic [15:0]      live_crc_value_o,
  output logic             crc_match_o,
  output logic             boot_done_o,
  output logic             fallback_o,
  output logic             pin_mode_o,
  output logic             serial_en_o,
  output logic [6:0]       slave_addr_o,
  output logic [5:0]       nvm_word_addr_o,
  output logic             nvm_busy_o
);
  ecl_nvm_if #(.AW(`ECL_NVM_AW), .DW(`ECL_NVM_DW)) nvm ();

  ecl_nvm_mem #(.AW(`ECL_NVM_AW), .DW(`ECL_NVM_DW)) u_mem (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .bus       (nvm.mem)
  );

  // CCITT CRC-16, one data word at a time, most significant bit first.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      fb = r[15] ^ w[i];
      r  = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ `ECL_CRC_POLY;
      end
    end
    return r;
  endfunction

  ecl_pkg::ecl_state_e st_q, st_d;
  logic [1:0]        sync1_q, sync2_q;
  logic [1:0]        bootcnt_q, bootcnt_d;
  logic [6:0]        idx_q, idx_d;
  logic [5:0]        pidx_q, pidx_d, ldi_q, ldi_d, naddr_q, naddr_d, cidx_q, cidx_d;
  logic [15:0]       crc_q, crc_d, live_q, live_d, ofs_q, ofs_d, rwa_q, rwa_d;
  logic [15:0]       rwd_q, rwd_d, ldw_q, ldw_d;
  logic              pend_q, pend_d, scan_ld_q, scan_ld_d, match_q, match_d, page_hi_q, page_hi_d;
  logic              fb_q, fb_d, a0_q, a0_d, ser_q, ser_d, pin_q, pin_d, done_q, done_d;
  logic              ack_q, ack_d, rwv_q, rwv_d, ldv_q, ldv_d, vco_recalibrate_q, vco_recalibrate_d;
  logic              cpage_q, cpage_d, cact_q, cact_d, busy_q, busy_d;
  logic [2:0]        bcnt_q, bcnt_d;
  logic [7:0]        vhi_q, vhi_d;
  logic [3:0]        key_q, key_d;
  logic [CNT_W-1:0]  wcnt_q, wcnt_d;
  logic [6:0]        saddr_q, saddr_d;
  logic [5:0]        pfirst, plast, cfg_word, cfirst, clast;
  logic [15:0]       val;
  logic              idle;

  assign pfirst   = page_hi_q ? `ECL_PG1_FIRST : `ECL_PG0_FIRST;
  assign plast    = page_hi_q ? `ECL_PG1_LAST : `ECL_PG0_LAST;
  assign cfg_word = pfirst + `ECL_CFG_REL_WORD;
  assign cfirst   = cpage_q ? `ECL_PG1_FIRST : `ECL_PG0_FIRST;
  assign clast    = cpage_q ? `ECL_PG1_LAST : `ECL_PG0_LAST;
  assign val      = {vhi_q, i2c_byte_i};
  assign idle     = (st_q == ecl_pkg::ST_IDLE);

  always_comb begin
    st_d      = st_q;
    bootcnt_d = bootcnt_q;
    idx_d     = idx_q;
    pend_d    = 1'b0;
    pidx_d    = pidx_q;
    scan_ld_d = scan_ld_q;
    crc_d     = crc_q;
    live_d    = live_q;
    match_d   = match_q;
    page_hi_d = page_hi_q;
    fb_d      = fb_q;
    a0_d      = a0_q;
    ser_d     = ser_q;
    pin_d     = pin_q;
    done_d    = done_q;
    bcnt_d    = bcnt_q;
    ofs_d     = ofs_q;
    vhi_d     = vhi_q;
    ack_d     = 1'b0;
    rwv_d     = 1'b0;
    rwa_d     = rwa_q;
    rwd_d     = rwd_q;
    ldv_d     = 1'b0;
    ldi_d     = ldi_q;
    ldw_d     = ldw_q;
    vco_recalibrate_d   = 1'b0;
    key_d     = key_q;
    naddr_d   = naddr_q;
    cpage_d   = cpage_q;
    cact_d    = cact_q;
    cidx_d    = cidx_q;
    wcnt_d    = wcnt_q;
    nvm.we    = 1'b0;
    nvm.re    = 1'b0;
    nvm.addr  = idx_q[5:0];
    nvm.wdata = commit_word_i;
    unique case (st_q)
      ecl_pkg::ST_BOOT: begin
        if (bootcnt_q == `ECL_SYNC_WAIT) begin
          if (sync2_q == ecl_pkg::LVL_MID) begin
            fb_d   = 1'b1;
            ser_d  = 1'b1;
            done_d = 1'b1;
            st_d   = ecl_pkg::ST_IDLE;
          end else begin
            page_hi_d = (sync2_q == ecl_pkg::LVL_HIGH);
            scan_ld_d = 1'b1;
            idx_d     = '0;
            crc_d     = `ECL_CRC_INIT;
            st_d      = ecl_pkg::ST_SCAN;
          end
        end else begin
          bootcnt_d = bootcnt_q + 2'd1;
        end
      end
      ecl_pkg::ST_SCAN: begin
        if (!idx_q[6]) begin
          nvm.re = 1'b1;
          pend_d = 1'b1;
          pidx_d = idx_q[5:0];
          idx_d  = idx_q + 7'd1;
        end
        if (pend_q) begin
          if (pidx_q != `ECL_CRC_WORD) begin
            crc_d = crc_step(crc_q, nvm.rdata);
          end
          if (scan_ld_q && (pidx_q <= `ECL_BASE_LAST || (pidx_q >= pfirst && pidx_q <= plast))) begin
            ldv_d = 1'b1;
            ldi_d = pidx_q;
            ldw_d = nvm.rdata;
          end
          if (scan_ld_q && pidx_q == cfg_word) begin
            a0_d  = nvm.rdata[`ECL_CFG_A0_BIT];
            ser_d = nvm.rdata[`ECL_CFG_SER_BIT];
            pin_d = !nvm.rdata[`ECL_CFG_SER_BIT];
          end
          if (pidx_q == `ECL_CRC_WORD) begin
            live_d    = crc_q;
            match_d   = (crc_q == nvm.rdata);
            done_d    = 1'b1;
            scan_ld_d = 1'b0;
            st_d      = ecl_pkg::ST_IDLE;
          end
        end
      end
      ecl_pkg::ST_IDLE: begin
      end
      ecl_pkg::ST_NVWR: begin
        if (wcnt_q == '0) begin
          st_d = cact_q ? ecl_pkg::ST_COMMIT : ecl_pkg::ST_IDLE;
        end else begin
          wcnt_d = wcnt_q - CNT_W'(1);
        end
      end
      ecl_pkg::ST_COMMIT: begin
        nvm.we   = 1'b1;
        nvm.addr = cidx_q;
        wcnt_d   = CNT_W'(WR_CYC - 1);
        st_d     = ecl_pkg::ST_NVWR;
        if (cidx_q == clast) begin
          cact_d = 1'b0;
        end else begin
          cidx_d = (cidx_q == `ECL_BASE_LAST) ? cfirst : cidx_q + 6'd1;
        end
      end
      default: begin
        st_d = ecl_pkg::ST_IDLE;
      end
    endcase
    if (i2c_start_i) begin
      bcnt_d = '0;
    end else if (i2c_stop_i) begin
      bcnt_d = `ECL_FRAME_BYTES;
    end else if (i2c_byte_valid_i && bcnt_q < `ECL_FRAME_BYTES) begin
      ack_d  = 1'b1;
      bcnt_d = bcnt_q + 3'd1;
      unique case (bcnt_q)
        3'd0: begin
          if (!(ser_q && done_q && i2c_byte_i[7:1] == saddr_q && !i2c_byte_i[0])) begin
            ack_d  = 1'b0;
            bcnt_d = `ECL_FRAME_BYTES;
          end
        end
        3'd1: ofs_d[15:8] = i2c_byte_i;
        3'd2: ofs_d[7:0] = i2c_byte_i;
        3'd3: vhi_d = i2c_byte_i;
        default: begin
          rwv_d = 1'b1;
          rwa_d = ofs_q;
          rwd_d = val;
          if (ofs_q == `ECL_OFS_CTRL) begin
            vco_recalibrate_d = val[`ECL_CTRL_VCO_RECALIBRATE_BIT];
            cpage_d = val[`ECL_CTRL_PAGE_BIT];
            if (idle && val[`ECL_CTRL_COMMIT_BIT] && key_q == `ECL_UNLOCK_KEY) begin
              cact_d = 1'b1;
              cidx_d = '0;
              st_d   = ecl_pkg::ST_COMMIT;
            end else if (idle && val[`ECL_CTRL_UPDCRC_BIT]) begin
              idx_d = '0;
              crc_d = `ECL_CRC_INIT;
              st_d  = ecl_pkg::ST_SCAN;
            end
          end else if (ofs_q == `ECL_OFS_LOCK) begin
            key_d = val[3:0];
          end else if (ofs_q == `ECL_OFS_NVM_ADDR && idle) begin
            naddr_d = val[5:0];
          end else if (ofs_q == `ECL_OFS_NVM_DATA && idle && key_q == `ECL_UNLOCK_KEY) begin
            nvm.we    = 1'b1;
            nvm.addr  = naddr_q;
            nvm.wdata = val;
            naddr_d   = naddr_q + 6'd1;
            wcnt_d    = CNT_W'(WR_CYC - 1);
            st_d      = ecl_pkg::ST_NVWR;
          end
        end
      endcase
    end
    busy_d  = (st_d != ecl_pkg::ST_IDLE);
    saddr_d = fb_d ? `ECL_ADDR_FALLBACK : {`ECL_ADDR_UPPER, a0_d};
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q      <= ecl_pkg::ST_BOOT;
      crc_q     <= `ECL_CRC_INIT;
      bcnt_q    <= `ECL_FRAME_BYTES;
      busy_q    <= 1'b1;
      saddr_q   <= {`ECL_ADDR_UPPER, 1'b0};
      {sync1_q, sync2_q, bootcnt_q, idx_q, pend_q, pidx_q, scan_ld_q, live_q, match_q} <= '0;
      {page_hi_q, fb_q, a0_q, ser_q, pin_q, done_q, ofs_q, vhi_q, ack_q, rwv_q, rwa_q, rwd_q} <= '0;
      {ldv_q, ldi_q, ldw_q, vco_recalibrate_q, key_q, naddr_q, cpage_q, cact_q, cidx_q, wcnt_q} <= '0;
    end else begin
      st_q      <= st_d;
      sync1_q   <= page_select_level_i;
      sync2_q   <= sync1_q;
      bootcnt_q <= bootcnt_d;
      idx_q     <= idx_d;
      pend_q    <= pend_d;
      pidx_q    <= pidx_d;
      scan_ld_q <= scan_ld_d;
      crc_q     <= crc_d;
      live_q    <= live_d;
      match_q   <= match_d;
      page_hi_q <= page_hi_d;
      fb_q      <= fb_d;
      a0_q      <= a0_d;
      ser_q     <= ser_d;
      pin_q     <= pin_d;
      done_q    <= done_d;
      bcnt_q    <= bcnt_d;
      ofs_q     <= ofs_d;
      vhi_q     <= vhi_d;
      ack_q     <= ack_d;
      rwv_q     <= rwv_d;
      rwa_q     <= rwa_d;
      rwd_q     <= rwd_d;
      ldv_q     <= ldv_d;
      ldi_q     <= ldi_d;
      ldw_q     <= ldw_d;
      vco_recalibrate_q   <= vco_recalibrate_d;
      key_q     <= key_d;
      naddr_q   <= naddr_d;
      cpage_q   <= cpage_d;
      cact_q    <= cact_d;
      cidx_q    <= cidx_d;
      wcnt_q    <= wcnt_d;
      busy_q    <= busy_d;
      saddr_q   <= saddr_d;
    end
  end

  assign {i2c_ack_o, reg_wr_valid_o, reg_wr_offset_o, reg_wr_data_o} = {ack_q, rwv_q, rwa_q, rwd_q};
  assign {load_valid_o, load_word_idx_o, load_word_o, commit_word_idx_o} = {ldv_q, ldi_q, ldw_q, cidx_q};
  assign {vco_recalibrate_o, live_crc_value_o, crc_match_o, boot_done_o} = {vco_recalibrate_q, live_q, match_q, done_q};
  assign {fallback_o, pin_mode_o, serial_en_o, slave_addr_o} = {fb_q, pin_q, ser_q, saddr_q};
  assign {nvm_word_addr_o, nvm_busy_o} = {naddr_q, busy_q};
endmodule
`default_nettype wire

// *** hdl/ecl_defs.svh ***
// Purpose: Constants of the configuration loader: map, fields, codes, timing.
// Assumes: One 250 MHz system clock.
// Notes:   Offsets of the control registers are local to this block.
`ifndef ECL_DEFS_SVH
`define ECL_DEFS_SVH
`define ECL_NVM_AW          6
`define ECL_NVM_DW          16
`define ECL_BASE_LAST       6'd15
`define ECL_PG0_FIRST       6'd16
`define ECL_PG0_LAST        6'd39
`define ECL_PG1_FIRST       6'd40
`define ECL_PG1_LAST        6'd63
`define ECL_CRC_WORD        6'h3f
`define ECL_CRC_POLY        16'h1021
`define ECL_CRC_INIT        16'hffff
`define ECL_ADDR_FALLBACK   7'h67
`define ECL_ADDR_UPPER      6'h34
`define ECL_UNLOCK_KEY      4'h5
`define ECL_CFG_REL_WORD    6'd20
`define ECL_CFG_A0_BIT      0
`define ECL_CFG_SER_BIT     1
`define ECL_OFS_CTRL        16'h0054
`define ECL_OFS_LOCK        16'h0055
`define ECL_OFS_NVM_ADDR    16'h0056
`define ECL_OFS_NVM_DATA    16'h0057
`define ECL_CTRL_VCO_RECALIBRATE_BIT  0
`define ECL_CTRL_COMMIT_BIT 1
`define ECL_CTRL_UPDCRC_BIT 2
`define ECL_CTRL_PAGE_BIT   3
`define ECL_NVM_WR_TIME_US  8000
`define ECL_CLK_MHZ         250
`define ECL_SYNC_WAIT       2'd3
`define ECL_FRAME_BYTES     3'd5
`endif

// *** hdl/ecl_pkg.sv ***
// Purpose: Types of the configuration loader.
// Assumes: Constants live in ecl_defs.svh.
// Notes:   States are one-hot.
package ecl_pkg;
  typedef enum logic [4:0] {
    ST_BOOT   = 5'b00001,
    ST_SCAN   = 5'b00010,
    ST_IDLE   = 5'b00100,
    ST_NVWR   = 5'b01000,
    ST_COMMIT = 5'b10000
  } ecl_state_e;

  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_HIGH = 2'h1,
    LVL_MID  = 2'h2
  } ecl_lvl_e;
endpackage

// *** hdl/ecl_nvm_if.sv ***
// Purpose: Port bundle between the loader and its configuration memory.
// Assumes: Read data appear one cycle after a read strobe.
// Notes:   None.
`timescale 1ns/1ps
`default_nettype none
interface ecl_nvm_if #(
  parameter int AW = 6,
  parameter int DW = 16
);
  logic          we;
  logic          re;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output re, output addr, output wdata, input rdata);
  modport mem  (input we, input re, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** hdl/ecl_nvm_mem.sv ***
// Purpose: Word array that stands for the non-volatile configuration store.
// Assumes: One access per cycle; read data come from a register.
// Notes:   Contents start at zero so that a first boot scan is defined.
`timescale 1ns/1ps
`default_nettype none
module ecl_nvm_mem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  ecl_nvm_if.mem    bus
);
  logic [DW-1:0] mem_q [2**AW] = '{default: '0};
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;

  always_comb begin
    rdata_d = bus.re ? mem_q[bus.addr] : rdata_q;
  end

  always_ff @(posedge clk_sys_i) begin
    if (bus.we) begin
      mem_q[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign bus.rdata = rdata_q;
endmodule
`default_nettype wire

// *** dv/ecl_loader_asserts.sv ***
// Purpose: Concurrent checks on the loader's top-level ports.
// Assumes: One clock domain with an asynchronous active-high reset.
// Notes:   Attached by bind from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module ecl_loader_asserts (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        i2c_byte_valid_i,
  input  wire logic        i2c_ack_o,
  input  wire logic        reg_wr_valid_o,
  input  wire logic [15:0] reg_wr_offset_o,
  input  wire logic [15:0] reg_wr_data_o,
  input  wire logic        load_valid_o,
  input  wire logic [5:0]  load_word_idx_o,
  input  wire logic        vco_recalibrate_o,
  input  wire logic        boot_done_o,
  input  wire logic        fallback_o,
  input  wire logic        pin_mode_o,
  input  wire logic        serial_en_o,
  input  wire logic [6:0]  slave_addr_o,
  input  wire logic [5:0]  nvm_word_addr_o,
  input  wire logic        nvm_busy_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  AST_ACK_CAUSE: assert property (i2c_ack_o |-> $past(i2c_byte_valid_i))
    else $error("ack without a received byte");
  AST_ACK_SERIAL: assert property (i2c_ack_o |-> serial_en_o && boot_done_o)
    else $error("ack while serial access is off");
  AST_FALLBACK_ADDR: assert property (fallback_o |-> slave_addr_o == 7'h67)
    else $error("fall-back address wrong");
  AST_ADDR_UPPER: assert property (boot_done_o && !fallback_o |-> slave_addr_o[6:1] == 6'h34)
    else $error("upper address bits wrong");
  AST_WR_FRAME: assert property (reg_wr_valid_o |-> i2c_ack_o)
    else $error("write forwarded without last ack");
  AST_ADDR_HOLD_BUSY: assert property (nvm_busy_o && $past(nvm_busy_o) && boot_done_o |-> $stable(nvm_word_addr_o))
    else $error("word address moved while busy");
  AST_PIN_MODE: assert property (boot_done_o |-> pin_mode_o == !serial_en_o)
    else $error("pin mode and serial enable disagree");
  AST_LOAD_IN_BOOT: assert property (load_valid_o |-> $past(nvm_busy_o) && !$past(boot_done_o))
    else $error("load word outside boot");
  AST_VCO_RECALIBRATE_CAUSE: assert property (vco_recalibrate_o |->
      (reg_wr_valid_o || $past(reg_wr_valid_o)) && reg_wr_offset_o == 16'h0054 && reg_wr_data_o[0])
    else $error("recalibration without its control write");
  AST_ADDR_FIXED: assert property (boot_done_o && $past(boot_done_o) |-> $stable(slave_addr_o))
    else $error("slave address changed after boot");
  AST_LOAD_ORDER: assert property (load_valid_o && $past(load_valid_o) && $past(load_word_idx_o) != 6'd15
      |-> load_word_idx_o == $past(load_word_idx_o) + 6'd1)
    else $error("load words out of order");
endmodule
`default_nettype wire

// *** dv/ecl_i2c_host.sv ***
// Purpose: Byte-level model of the serial host that configures the loader.
// Assumes: Inputs of the loader change at the falling clock edge.
// Notes:   Idle byte lines show the inverse of the last byte so stale data never looks valid.
`timescale 1ns/1ps
`default_nettype none
module ecl_i2c_host (
  input  wire logic clk_sys_i,
  input  wire logic ack_i,
  output logic      start_o,
  output logic      stop_o,
  output logic      byte_valid_o,
  output logic [7:0] byte_o
);
  initial begin
    start_o = 1'b0;
    stop_o = 1'b0;
    byte_valid_o = 1'b0;
    byte_o = 8'h00;
  end
  task automatic send_byte(input logic [7:0] b, output logic a);
    @(negedge clk_sys_i);
    byte_valid_o = 1'b1;
    byte_o = b;
    @(negedge clk_sys_i);
    byte_valid_o = 1'b0;
    byte_o = ~b;
    a = (ack_i === 1'b1);
    @(negedge clk_sys_i);
    a = a | (ack_i === 1'b1);
  endtask
  // Address byte, offset high and low, value high and low.
  task automatic frame(input logic [6:0] adr, input logic rw, input logic [15:0] ofs,
                       input logic [15:0] dat, output logic [4:0] acks);
    logic [7:0] b [5];
    b = '{{adr, rw}, ofs[15:8], ofs[7:0], dat[15:8], dat[7:0]};
    @(negedge clk_sys_i);
    start_o = 1'b1;
    @(negedge clk_sys_i);
    start_o = 1'b0;
    for (int k = 0; k < 5; k++) send_byte(b[k], acks[4-k]);
    stop_o = 1'b1;
    @(negedge clk_sys_i);
    stop_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** dv/ecl_loader_tb_top.sv ***
// Purpose: Self-checking bench of the configuration loader.
// Assumes: Store contents survive a reset, as a non-volatile store does.
// Notes:   Word write time shortened through WR_CYC.
`timescale 1ns/1ps
`default_nettype none
`include "ecl_defs.svh"
module ecl_loader_tb_top;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [1:0]  page_select_level_i = 2'h2;
  logic        i2c_start_i, i2c_stop_i, i2c_byte_valid_i, i2c_ack_o, reg_wr_valid_o, load_valid_o;
  logic        vco_recalibrate_o, crc_match_o, boot_done_o, fallback_o, pin_mode_o, serial_en_o, nvm_busy_o;
  logic [7:0]  i2c_byte_i;
  logic [15:0] commit_word_i, reg_wr_offset_o, reg_wr_data_o, load_word_o, live_crc_value_o, crc;
  logic [5:0]  load_word_idx_o, commit_word_idx_o, nvm_word_addr_o;
  logic [6:0]  slave_addr_o, me;
  logic [15:0] img [64];
  logic [63:0] cm_seen = '0;
  logic [4:0]  acks;
  logic        cm_on = 1'b0;
  logic [8:0]  rows [4] = '{{7'h67, 1'b0, 1'b1}, {7'h68, 1'b0, 1'b0}, {7'h67, 1'b1, 1'b0}, {7'h69, 1'b0, 1'b0}};
  int          num_errors = 0, cmp_count = 0, ld_n = 0, rec_n = 0, cyc = 0, pg_first = 40, wv_n = 0;

  // Register bank stand-in: every committed word is a known function of its index.
  assign commit_word_i = {10'h2a5, commit_word_idx_o};
  always #2 clk_sys_i = ~clk_sys_i;

  ecl_loader #(.WR_CYC(40)) dut (.clk_sys_i, .sys_rst_i, .page_select_level_i, .i2c_start_i, .i2c_stop_i,
    .i2c_byte_valid_i, .i2c_byte_i, .commit_word_i, .i2c_ack_o, .reg_wr_valid_o, .reg_wr_offset_o,
    .reg_wr_data_o, .load_valid_o, .load_word_idx_o, .load_word_o, .commit_word_idx_o, .vco_recalibrate_o,
    .live_crc_value_o, .crc_match_o, .boot_done_o, .fallback_o, .pin_mode_o, .serial_en_o, .slave_addr_o,
    .nvm_word_addr_o, .nvm_busy_o);
  ecl_i2c_host host (.clk_sys_i, .ack_i(i2c_ack_o), .start_o(i2c_start_i), .stop_o(i2c_stop_i),
    .byte_valid_o(i2c_byte_valid_i), .byte_o(i2c_byte_i));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_idle();
    repeat (3) @(negedge clk_sys_i);
    for (int n = 0; n < 3000 && nvm_busy_o !== 1'b0; n++) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [15:0] ofs, input logic [15:0] dat);
    host.frame(me, 1'b0, ofs, dat, acks);
    wait_idle();
  endtask
  task automatic boot(input logic [1:0] l);
    sys_rst_i = 1'b1;
    page_select_level_i = l;
    ld_n = 0;
    repeat (12) @(negedge clk_sys_i);
    chk({9'h0, slave_addr_o}, 16'h0068);
    chk({15'h0, nvm_busy_o}, 16'h0001);
    sys_rst_i = 1'b0;
    for (int n = 0; n < 300 && boot_done_o !== 1'b1; n++) @(negedge clk_sys_i);
    wait_idle();
    chk({15'h0, boot_done_o}, 16'h0001);
  endtask
  function automatic logic [15:0] crc_of();
    logic [15:0] c;
    c = `ECL_CRC_INIT;
    for (int i = 0; i < 63; i++)
      for (int b = 15; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ img[i][b]) ? `ECL_CRC_POLY : 16'h0000);
    return c;
  endfunction

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (vco_recalibrate_o === 1'b1) rec_n <= rec_n + 1;
    if (reg_wr_valid_o === 1'b1) wv_n <= wv_n + 1;
    if (cm_on && nvm_busy_o === 1'b1) cm_seen[commit_word_idx_o] <= 1'b1;
    if (load_valid_o === 1'b1) begin
      chk({10'h0, load_word_idx_o}, 16'(ld_n < 16 ? ld_n : ld_n - 16 + pg_first));
      chk(load_word_o, img[load_word_idx_o]);
      ld_n <= ld_n + 1;
    end
  end
  always @(negedge clk_sys_i) begin
    if (cyc > 40000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    for (int i = 0; i < 64; i++) img[i] = {2'b10, 6'(i), 2'b01, ~6'(i)};
    img[36] = 16'h0001;
    img[60] = 16'h0002;
    img[63] = crc_of();
    boot(2'h2);
    chk({9'h0, slave_addr_o}, {9'h0, `ECL_ADDR_FALLBACK});
    chk({14'h0, fallback_o, serial_en_o}, 16'h0003);
    for (int r = 0; r < 4; r++) begin
      host.frame(rows[r][8:2], rows[r][1], 16'h0010, 16'h0100 + 16'(r), acks);
      chk({11'h0, acks}, rows[r][0] ? 16'h001f : 16'h0000);
      if (rows[r][0]) begin
        chk(reg_wr_offset_o, 16'h0010);
        chk(reg_wr_data_o, 16'h0100 + 16'(r));
      end
    end
    me = `ECL_ADDR_FALLBACK;
    wv_n = 0;
    for (int o = 32'h53; o >= 0; o--) begin
      host.frame(me, 1'b0, 16'(o), ~16'(o), acks);
      chk(reg_wr_offset_o, 16'(o));
      chk(reg_wr_data_o, ~16'(o));
    end
    chk(16'(wv_n), 16'h0054);
    wr(`ECL_OFS_NVM_DATA, 16'hdead);
    chk({10'h0, nvm_word_addr_o}, 16'h0000);
    wr(`ECL_OFS_LOCK, {12'h0, `ECL_UNLOCK_KEY});
    wr(`ECL_OFS_NVM_ADDR, 16'h0000);
    for (int i = 0; i < 64; i++) begin
      host.frame(me, 1'b0, `ECL_OFS_NVM_DATA, img[i], acks);
      if (i == 5) host.frame(me, 1'b0, `ECL_OFS_NVM_ADDR, 16'h0030, acks);
      wait_idle();
      chk({10'h0, nvm_word_addr_o}, 16'(i + 1) & 16'h003f);
    end
    crc = crc_of();
    wr(`ECL_OFS_CTRL, 16'h0004);
    chk(live_crc_value_o, crc);
    chk({15'h0, crc_match_o}, 16'h0001);
    wr(`ECL_OFS_NVM_ADDR, 16'h003f);
    wr(`ECL_OFS_NVM_DATA, ~crc);
    wr(`ECL_OFS_CTRL, 16'h0004);
    chk({15'h0, crc_match_o}, 16'h0000);
    wr(`ECL_OFS_NVM_ADDR, 16'h003f);
    wr(`ECL_OFS_NVM_DATA, crc);
    chk({11'h0, acks}, 16'h001f);
    chk({10'h0, nvm_word_addr_o}, 16'h0000);
    wr(`ECL_OFS_CTRL, 16'h0001);
    chk(16'(rec_n), 16'h0001);
    pg_first = 40;
    boot(2'h1);
    chk({9'h0, slave_addr_o}, 16'h0068);
    chk(16'(ld_n), 16'd40);
    chk({13'h0, crc_match_o, serial_en_o, pin_mode_o}, 16'h0006);
    me = 7'h68;
    wr(`ECL_OFS_LOCK, 16'h0005);
    chk({11'h0, acks}, 16'h001f);
    cm_on = 1'b1;
    wr(`ECL_OFS_CTRL, 16'h000a);
    cm_on = 1'b0;
    chk(cm_seen[63:48], 16'hffff);
    chk(cm_seen[47:32], 16'hff00);
    chk(cm_seen[31:16], 16'h0000);
    chk(cm_seen[15:0], 16'hffff);
    for (int i = 0; i < 64; i++) if (i < 16 || i > 39) img[i] = {10'h2a5, 6'(i)};
    crc = crc_of();
    wr(`ECL_OFS_CTRL, 16'h0004);
    chk(live_crc_value_o, crc);
    wr(`ECL_OFS_NVM_ADDR, 16'h003f);
    wr(`ECL_OFS_NVM_DATA, crc);
    img[63] = crc;
    pg_first = 16;
    boot(2'h0);
    chk({9'h0, slave_addr_o}, 16'h0069);
    chk({13'h0, crc_match_o, serial_en_o, pin_mode_o}, 16'h0005);
    chk(16'(ld_n), 16'd40);
    host.frame(7'h69, 1'b0, `ECL_OFS_CTRL, 16'h0000, acks);
    chk({11'h0, acks}, 16'h0000);
    close_out();
  end
endmodule
bind ecl_loader ecl_loader_asserts u_chk (.clk_sys_i, .sys_rst_i, .i2c_byte_valid_i, .i2c_ack_o, .reg_wr_valid_o,
  .reg_wr_offset_o, .reg_wr_data_o, .load_valid_o, .load_word_idx_o, .vco_recalibrate_o, .boot_done_o,
  .fallback_o, .pin_mode_o, .serial_en_o, .slave_addr_o, .nvm_word_addr_o, .nvm_busy_o);
`default_nettype wire
